// ### common/arlc_pkg.sv
// package: register map, field layout, timing and types of the result-lock converter control
package arlc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CH_W = 4;
  localparam int RES_W = 10;
  localparam int LOW_W = 2;
  localparam int HIGH_W = 8;
  localparam int EVT_W = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CSR_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] RES_HIGH_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] RES_LOW_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 8'h0c;
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] RES_LOW_ALT_ADDR = 8'h14;

  // field positions
  localparam int CSR_CH_LSB = 0;
  localparam int CSR_ON_BIT = 5;
  localparam int CSR_SETTLE_BIT = 6;
  localparam int CSR_DONE_BIT = 7;
  localparam int RES_HIGH_LSB = 2;
  localparam int EVT_LOST_BIT = 0;
  localparam int EVT_ABORT_BIT = 1;

  // reset values
  localparam logic CSR_ON_RST = 1'b0;
  localparam logic [CH_W-1:0] CSR_CH_RST = 4'h0;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // timing
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int WAKEUP_SETTLE_TIME_NS = 1000;
  localparam int SETTLE_CYCLES = (WAKEUP_SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES);
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = SETTLE_W'(0);
  localparam logic [SETTLE_W-1:0] SETTLE_ONE = SETTLE_W'(1);

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_BUSY = 2'b10
  } arlc_seq_state_type;

  typedef struct packed {
    logic power;
    logic start;
    logic abort;
    logic [CH_W-1:0] channel;
  } arlc_analog_out_type;
endpackage

// ### sim/arlc_top_bench.sv
// bench: register-level tests of the result-lock converter control
`timescale 1ns/100ps
`default_nettype none
module arlc_top_bench
  import arlc_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic halt_mode = 1'b0;
  logic wait_mode = 1'b0;
  logic analog_done = 1'b0;
  logic [RES_W-1:0] analog_data = 10'h000;
  logic pready;
  logic pslverr;
  logic irq;
  logic er;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rv;
  arlc_analog_out_type to_analog;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  always #2 clock = ~clock;
  arlc_top arlc_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .halt_mode(halt_mode), .wait_mode(wait_mode),
    .analog_done(analog_done), .analog_data(analog_data), .to_analog(to_analog), .irq(irq));
  task complete_run;
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      complete_run;
    end
  end
  // one apb transfer, held until pready
  task acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock);
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    acc(1'b0, a, 32'h0000_0000);
    chk(rv, e);
  endtask
  // one finished sample from the analog side
  task conv(input logic [RES_W-1:0] d);
    analog_data <= d;
    @(posedge clock);
    analog_done <= 1'b1;
    repeat (6) @(posedge clock);
    analog_done <= 1'b0;
    analog_data <= ~d;
    repeat (3) @(posedge clock);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(CSR_ADDR, 32'h0000_0000);
    acc(1'b0, 8'h18, 32'h0000_0000);
    chk({er, rv[30:0]}, 32'h8000_0000);
    acc(1'b1, CSR_ADDR, 32'h0000_0023);
    repeat (3) @(posedge clock);
    chk({25'h0, to_analog}, 32'h0000_0043);
    conv(10'h2b5);
    rd(CSR_ADDR, 32'h0000_00a3);
    rd(RES_LOW_ADDR, 32'h0000_0001);
    conv(10'h0ca);
    rd(EVT_STATUS_ADDR, 32'h0000_0001);
    rd(RES_HIGH_ADDR, 32'h0000_00ad);
    rd(CSR_ADDR, 32'h0000_0023);
    acc(1'b1, EVT_MASK_ADDR, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0001);
    acc(1'b1, EVT_STATUS_ADDR, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    conv(10'h0ca);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(RES_LOW_ADDR, 32'h0000_0002);
    rd(RES_HIGH_ADDR, 32'h0000_0032);
    conv(10'h3ff);
    rd(CSR_ADDR, 32'h0000_00a3);
    rd(RES_HIGH_ADDR, 32'h0000_00ff);
    rd(CSR_ADDR, 32'h0000_0023);
    conv(10'h155);
    acc(1'b1, CSR_ADDR, 32'h0000_0025);
    rd(CSR_ADDR, 32'h0000_0025);
    chk({25'h0, to_analog}, 32'h0000_0045);
    rd(EVT_STATUS_ADDR, 32'h0000_0002);
    acc(1'b1, EVT_STATUS_ADDR, 32'h0000_0002);
    conv(10'h200);
    rd(RES_LOW_ADDR, 32'h0000_0000);
    acc(1'b1, CSR_ADDR, 32'h0000_0005);
    repeat (3) @(posedge clock);
    chk({31'h0, to_analog.power}, 32'h0000_0000);
    acc(1'b1, CSR_ADDR, 32'h0000_0025);
    conv(10'h1c4);
    rd(RES_HIGH_ADDR, 32'h0000_0071);
    wait_mode <= 1'b1;
    conv(10'h0f3);
    rd(RES_LOW_ADDR, 32'h0000_0003);
    rd(RES_HIGH_ADDR, 32'h0000_003c);
    wait_mode <= 1'b0;
    halt_mode <= 1'b1;
    repeat (3) @(posedge clock);
    chk({31'h0, to_analog.power}, 32'h0000_0000);
    halt_mode <= 1'b0;
    repeat (3) @(posedge clock);
    rd(CSR_ADDR, 32'h0000_0065);
    complete_run;
  end
endmodule
`default_nettype wire

// ### sim/arlc_top_props.sv
// checker: port-level properties of the result-lock converter control
`timescale 1ns/100ps
`default_nettype none
module arlc_top_props
  import arlc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic analog_done,
  input wire logic [RES_W-1:0] analog_data,
  input wire arlc_analog_out_type to_analog,
  input wire logic irq
);
  logic wr;
  logic cw;
  logic chg;
  logic on_q;
  logic [CH_W-1:0] ch_q;
  logic [EVT_W-1:0] mask_q;
  assign wr = psel && penable && !pready && pwrite && pstrb[0];
  assign cw = wr && paddr == CSR_ADDR;
  assign chg = cw && on_q && pwdata[CSR_ON_BIT] && !halt_mode && pwdata[CH_W-1:0] != ch_q;
  // shadow of the written control and mask fields
  always_ff @(posedge clock) begin
    if (rst) begin
      ch_q <= CSR_CH_RST;
      on_q <= CSR_ON_RST;
      mask_q <= EVT_RST;
    end else if (cw) begin
      ch_q <= pwdata[CH_W-1:0];
      on_q <= pwdata[CSR_ON_BIT];
    end else if (wr && paddr == EVT_MASK_ADDR) begin
      mask_q <= pwdata[EVT_W-1:0];
    end
  end
  property p_chg_abort;
    @(posedge clock) disable iff (rst) chg |=> to_analog.abort;
  endproperty
  a_chg_abort: assert property (p_chg_abort) else $error("no abort");
  property p_chg_start;
    @(posedge clock) disable iff (rst)
    chg |-> ##2 (to_analog.start && to_analog.channel == $past(pwdata[CH_W-1:0], 2));
  endproperty
  a_chg_start: assert property (p_chg_start) else $error("no restart");
  property p_on_start;
    @(posedge clock) disable iff (rst)
    cw && !on_q && pwdata[CSR_ON_BIT] && !halt_mode |-> ##[1:2] (to_analog.power && to_analog.start);
  endproperty
  a_on_start: assert property (p_on_start) else $error("no start");
  property p_off_power;
    @(posedge clock) disable iff (rst) cw && on_q && !pwdata[CSR_ON_BIT] |-> ##[1:2] !to_analog.power;
  endproperty
  a_off_power: assert property (p_off_power) else $error("power kept");
  property p_halt_off;
    @(posedge clock) disable iff (rst) halt_mode |=> !to_analog.power;
  endproperty
  a_halt_off: assert property (p_halt_off) else $error("power in halt");
  property p_start_pow;
    @(posedge clock) disable iff (rst) to_analog.start |-> to_analog.power;
  endproperty
  a_start_pow: assert property (p_start_pow) else $error("start unpowered");
  property p_done_start;
    @(posedge clock) disable iff (rst)
    $rose(analog_done) && to_analog.power && on_q && !halt_mode |-> ##[2:4] to_analog.start;
  endproperty
  a_done_start: assert property (p_done_start) else $error("no next start");
  property p_irq_mask;
    @(posedge clock) disable iff (rst) !(|mask_q) && !(|$past(mask_q)) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
endmodule
bind arlc_top arlc_top_props arlc_top_props_i (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .halt_mode(halt_mode),
  .wait_mode(wait_mode), .analog_done(analog_done), .analog_data(analog_data),
  .to_analog(to_analog), .irq(irq));
`default_nettype wire

// ### src/arlc_conv_seq.sv
// conversion sequencer: drives the analog macro and returns each finished sample
`timescale 1ns/100ps
`default_nettype none
module arlc_conv_seq
  import arlc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [CH_W-1:0] channel,
  input wire logic analog_done,
  input wire logic [RES_W-1:0] analog_data,
  output arlc_analog_out_type to_analog,
  output logic done,
  output logic [RES_W-1:0] result
);
  typedef struct packed {
    arlc_seq_state_type state;
    logic done_s1;
    logic done_s2;
    logic done_prev;
    logic [RES_W-1:0] data_s1;
    logic [RES_W-1:0] data_s2;
    arlc_analog_out_type ana;
    logic done;
    logic [RES_W-1:0] result;
  } arlc_seq_state_all_type;

  arlc_seq_state_all_type q;
  arlc_seq_state_all_type d;
  logic done_edge;

  always_comb begin
    d = q;
    d.done_s1 = analog_done;
    d.done_s2 = q.done_s1;
    d.done_prev = q.done_s2;
    d.data_s1 = analog_data;
    d.data_s2 = q.data_s1;
    d.ana.power = run;
    d.ana.start = 1'b0;
    d.ana.abort = 1'b0;
    d.done = 1'b0;
    done_edge = q.done_s2 & ~q.done_prev;
    case (q.state)
      SEQ_IDLE: begin
        if (run && !restart) begin
          d.ana.start = 1'b1;
          d.ana.channel = channel;
          d.state = SEQ_BUSY;
        end
      end
      SEQ_BUSY: begin
        if (!run || restart) begin
          d.ana.abort = 1'b1;
          d.state = SEQ_IDLE;
        end else if (done_edge) begin
          d.done = 1'b1;
          d.result = q.data_s2;
          d.ana.start = 1'b1;
        end
      end
      default: begin
        d.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{state: SEQ_IDLE, data_s1: RES_RST, data_s2: RES_RST, result: RES_RST,
             ana: '{power: 1'b0, start: 1'b0, abort: 1'b0, channel: CSR_CH_RST},
             default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign to_analog = q.ana;
  assign done = q.done;
  assign result = q.result;
endmodule
`default_nettype wire

// ### src/arlc_top.sv
// top: apb registers, result lock, flag and power control of the converter
// What this block does
// - setting converter_on powers the converter and converts the channel continuously.
// - each finished conversion sets the done flag and stores the 10-bit result unless the result bytes are locked.
// - reading the high result byte clears the done flag.
// - writing a new channel select aborts the running conversion at once.
// - a channel change clears done and restarts on the new channel.
// - reading the low result byte while converter_on is set locks both result bytes.
// - the lock is released by a high byte read or clearing converter_on.
// - while locked, new results are not stored until the high read.
// - clearing converter_on disables the converter to save power.
// - wait mode does not change converter operation.
// - halt disables the converter; software waits the settle time after wakeup.
`timescale 1ns/100ps
`default_nettype none
module arlc_top
  import arlc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic analog_done,
  input wire logic [RES_W-1:0] analog_data,
  output arlc_analog_out_type to_analog,
  output logic irq
);
  typedef struct packed {
    logic on;
    logic [CH_W-1:0] channel;
    logic done_flag;
    logic locked;
    logic [RES_W-1:0] result;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic [SETTLE_W-1:0] settle_cnt;
    logic halt_prev;
    logic rdy;
    logic [DATA_W-1:0] rdata;
    logic slverr;
  } arlc_top_state_type;

  arlc_top_state_type q;
  arlc_top_state_type d;

  logic acc;
  logic rd;
  logic wr;
  logic hit_csr;
  logic hit_high;
  logic hit_low;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic wr_csr;
  logic rd_high;
  logic rd_low;
  logic ch_change;
  logic powered;
  logic seq_done;
  logic [RES_W-1:0] seq_result;
  logic [DATA_W-1:0] rmux;
  logic [EVT_W-1:0] evt_set;

  // converter runs whenever on and not halted; wait mode is ignored on purpose
  assign powered = q.on & ~halt_mode;

  // one access edge per apb transfer: first access cycle, answered one cycle later
  assign acc = psel & penable & ~q.rdy;
  assign rd = acc & ~pwrite;
  assign wr = acc & pwrite;
  assign hit_csr = (paddr == CSR_ADDR);
  assign hit_high = (paddr == RES_HIGH_ADDR);
  assign hit_low = (paddr == RES_LOW_ADDR) | (paddr == RES_LOW_ALT_ADDR);
  assign hit_status = (paddr == EVT_STATUS_ADDR);
  assign hit_mask = (paddr == EVT_MASK_ADDR);
  assign mapped = hit_csr | hit_high | hit_low | hit_status | hit_mask;

  assign wr_csr = wr & hit_csr & pstrb[0];
  assign rd_high = rd & hit_high;
  assign rd_low = rd & hit_low;
  assign ch_change = wr_csr && (pwdata[CSR_CH_LSB +: CH_W] != q.channel);

  arlc_conv_seq arlc_conv_seq_i (
    .clock(clock),
    .rst(rst),
    .run(powered),
    .restart(ch_change),
    .channel(q.channel),
    .analog_done(analog_done),
    .analog_data(analog_data),
    .to_analog(to_analog),
    .done(seq_done),
    .result(seq_result)
  );

  // read data mux
  always_comb begin
    rmux = RDATA_RST;
    if (hit_csr) begin
      rmux[CSR_CH_LSB +: CH_W] = q.channel;
      rmux[CSR_ON_BIT] = q.on;
      rmux[CSR_SETTLE_BIT] = (q.settle_cnt != SETTLE_ZERO);
      rmux[CSR_DONE_BIT] = q.done_flag;
    end else if (hit_high) begin
      rmux[HIGH_W-1:0] = q.result[RES_HIGH_LSB +: HIGH_W];
    end else if (hit_low) begin
      rmux[LOW_W-1:0] = q.result[LOW_W-1:0];
    end else if (hit_status) begin
      rmux[EVT_W-1:0] = q.evt_status;
    end else if (hit_mask) begin
      rmux[EVT_W-1:0] = q.evt_mask;
    end
  end

  always_comb begin
    d = q;
    evt_set = EVT_RST;
    d.rdy = acc;
    d.halt_prev = halt_mode;

    // apb answer, registered
    if (acc) begin
      d.slverr = ~mapped;
      d.rdata = pwrite ? RDATA_RST : rmux;
    end

    // control register write
    if (wr_csr) begin
      d.on = pwdata[CSR_ON_BIT];
      if (ch_change) begin
        d.channel = pwdata[CSR_CH_LSB +: CH_W];
        d.done_flag = 1'b0;
        if (powered) begin
          evt_set[EVT_ABORT_BIT] = 1'b1;
        end
      end
      if (!pwdata[CSR_ON_BIT]) begin
        d.locked = 1'b0;
      end
    end

    // event registers: write one to clear, mask plain
    if (wr && hit_status && pstrb[0]) begin
      d.evt_status = q.evt_status & ~pwdata[EVT_W-1:0];
    end
    if (wr && hit_mask && pstrb[0]) begin
      d.evt_mask = pwdata[EVT_W-1:0];
    end

    // result byte reads
    if (rd_low && q.on) begin
      d.locked = 1'b1;
    end
    if (rd_high) begin
      d.locked = 1'b0;
      d.done_flag = 1'b0;
    end

    // a finished sample; one from an aborted channel is dropped
    if (seq_done && !ch_change) begin
      d.done_flag = 1'b1;
      if (!q.locked && !rd_low) begin
        d.result = seq_result;
      end else begin
        evt_set[EVT_LOST_BIT] = 1'b1;
      end
    end

    // set wins over clear
    d.evt_status = d.evt_status | evt_set;

    // settle window after leaving halt
    if (q.halt_prev && !halt_mode) begin
      d.settle_cnt = SETTLE_LOAD;
    end else if (halt_mode) begin
      d.settle_cnt = SETTLE_ZERO;
    end else if (q.settle_cnt != SETTLE_ZERO) begin
      d.settle_cnt = q.settle_cnt - SETTLE_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{on: CSR_ON_RST, channel: CSR_CH_RST, result: RES_RST,
             evt_status: EVT_RST, evt_mask: EVT_RST, settle_cnt: SETTLE_ZERO,
             rdata: RDATA_RST, default: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pready = q.rdy;
  assign prdata = q.rdata;
  assign pslverr = q.slverr;
  // only lost-sample and abort events reach irq; completion never does
  assign irq = |(q.evt_status & q.evt_mask);
endmodule
`default_nettype wire
